//--- cifr_pkg.sv
// Constants for the control input function router: register map, fields, reset values.
// Assumes a single 200 MHz core clock and an AXI4-Lite register bus with 32-bit data.
package cifr_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] BANK_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] EVT_OFS = 8'h0C;

    localparam int CFG_BLK_LOW_OC = 0;
    localparam int CFG_BLK_HIGH_OC = 1;
    localparam int CFG_BLK_LOW_EF = 2;
    localparam int CFG_BLK_HIGH_EF = 3;
    localparam int CFG_BANK_EXT = 4;
    localparam int CFG_IND_RST = 5;
    localparam int CFG_REL_RST = 6;
    localparam int CFG_FULL_RST = 7;

    localparam int STAT_IN = 0;
    localparam int STAT_BLK_LSB = 1;
    localparam int STAT_BANK = 5;
    localparam int STAT_EXT = 6;

    localparam int EVT_IND = 0;
    localparam int EVT_REL = 1;
    localparam int EVT_FULL = 2;
    localparam int EVT_REJ = 3;

    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic BANK_MAIN = 1'b0;
    localparam logic BANK_SECOND = 1'b1;
    localparam logic [3:0] EVT_RST = 4'h0;
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Tells whether a byte address falls on one of the mapped registers.
    function automatic logic addrHit(input logic [7:0] addr);
        addrHit = (addr == CFG_OFS) || (addr == BANK_OFS) || (addr == STAT_OFS) || (addr == EVT_OFS);
    endfunction : addrHit

endpackage : cifr_pkg

//--- cifr_axil_slave.sv
// AXI4-Lite slave front end: takes one write and one read at a time.
// Assumes the parent decodes the write strobe and supplies read data combinationally.
`timescale 1ns/1ps
`default_nettype none

module cifr_axil_slave (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wrEn,
    output logic [7:0] wrAddr,
    output logic [31:0] wrData,
    output logic [3:0] wrStrb,
    output logic [7:0] rdAddr,
    input wire logic [31:0] rdData
);

    typedef struct packed {
        logic awGot;
        logic wGot;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cifr_axil_st_t;

    cifr_axil_st_t st_ff;
    cifr_axil_st_t nxt_st;

    assign s_axi_awready = !st_ff.awGot && !st_ff.bvalid;
    assign s_axi_wready = !st_ff.wGot && !st_ff.bvalid;
    assign s_axi_arready = !st_ff.rvalid;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rdata = st_ff.rdata;
    assign s_axi_rresp = st_ff.rresp;
    assign wrEn = st_ff.awGot && st_ff.wGot && !st_ff.bvalid;
    assign wrAddr = st_ff.addr;
    assign wrData = st_ff.data;
    assign wrStrb = st_ff.strb;
    assign rdAddr = s_axi_araddr;

    always_comb
    begin
        nxt_st = st_ff;
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_st.awGot = 1'b1;
            nxt_st.addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_st.wGot = 1'b1;
            nxt_st.data = s_axi_wdata;
            nxt_st.strb = s_axi_wstrb;
        end
        if (wrEn)
        begin
            nxt_st.awGot = 1'b0;
            nxt_st.wGot = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = cifr_pkg::addrHit(st_ff.addr) ? cifr_pkg::RESP_OKAY : cifr_pkg::RESP_SLVERR;
        end
        else if (st_ff.bvalid && s_axi_bready)
        begin
            nxt_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rdData;
            nxt_st.rresp = cifr_pkg::addrHit(s_axi_araddr) ? cifr_pkg::RESP_OKAY : cifr_pkg::RESP_SLVERR;
        end
        else if (st_ff.rvalid && s_axi_rready)
        begin
            nxt_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

endmodule : cifr_axil_slave

`default_nettype wire

//--- cifr_router.sv
// Routes one external control input to stage blocking, bank selection and reset actions.
// Assumes the control input and panel request are synchronous to core_clk.
// Behaviour
// - With config bits one to four clear, the input blocks no protection stage.
// - Config bit one set: input active blocks the low-set overcurrent stage.
// - Config bit two set: input active blocks the high-set overcurrent stage.
// - Config bit three set: input active blocks the low-set earth-fault stage.
// - Config bit four set: input active blocks the high-set earth-fault stage.
// - Bit five clear: bank follows the serial command or panel pushbuttons.
// - Bit five set: main bank while input inactive, second bank while active.
// - Bit five set: serial and panel bank selections are rejected.
// - Bit six set: input activation clears the operation indicators.
// - Bit seven set: input activation clears indicators and output relays.
// - Bit eight set: input activation does full reset, erasing recorded values.
`timescale 1ns/1ps
`default_nettype none

module cifr_router (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic externalControlInput,
    input wire logic panelBankReq,
    input wire logic panelBankSel,
    output logic blockLowOc,
    output logic blockHighOc,
    output logic blockLowEarthFault,
    output logic blockHighEarthFault,
    output logic activeBank,
    output logic indicatorResetPulse,
    output logic relayResetPulse,
    output logic fullResetPulse
);

    typedef struct packed {
        logic [7:0] cfg;
        logic bankReq;
        logic prevIn;
        logic [3:0] blk;
        logic bank;
        logic indPulse;
        logic relPulse;
        logic fullPulse;
        logic [3:0] evt;
    } cifr_router_st_t;

    cifr_router_st_t st_ff;
    cifr_router_st_t nxt_st;

    logic wrEn;
    logic [7:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0] wrStrb;
    logic [7:0] rdAddr;
    logic [31:0] rdData;
    logic wrCfg;
    logic wrBank;
    logic wrEvt;
    logic inRise;
    logic extBank;
    logic [3:0] blkNow;
    logic [3:0] evtSet;
    logic bankRejected;

    // Tells whether a write hits the given register with the low byte lane enabled.
    function automatic logic regWrite(
        input logic en,
        input logic [7:0] addr,
        input logic [3:0] strb,
        input logic [7:0] ofs
    );
        regWrite = en && (addr == ofs) && strb[0];
    endfunction : regWrite

    cifr_axil_slave u_axil (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wrEn(wrEn),
        .wrAddr(wrAddr),
        .wrData(wrData),
        .wrStrb(wrStrb),
        .rdAddr(rdAddr),
        .rdData(rdData)
    );

    // Register write decode.
    always_comb
    begin
        wrCfg = regWrite(wrEn, wrAddr, wrStrb, cifr_pkg::CFG_OFS);
        wrBank = regWrite(wrEn, wrAddr, wrStrb, cifr_pkg::BANK_OFS);
        wrEvt = regWrite(wrEn, wrAddr, wrStrb, cifr_pkg::EVT_OFS);
    end

    // Edge view of the control input and the external bank mode bit.
    always_comb
    begin
        inRise = externalControlInput && !st_ff.prevIn;
        extBank = st_ff.cfg[cifr_pkg::CFG_BANK_EXT];
    end

    // Stage blocking follows the input level, gated per stage by config bits one to four.
    always_comb
    begin
        blkNow = 4'h0;
        if (externalControlInput)
        begin
            blkNow[0] = st_ff.cfg[cifr_pkg::CFG_BLK_LOW_OC];
            blkNow[1] = st_ff.cfg[cifr_pkg::CFG_BLK_HIGH_OC];
            blkNow[2] = st_ff.cfg[cifr_pkg::CFG_BLK_LOW_EF];
            blkNow[3] = st_ff.cfg[cifr_pkg::CFG_BLK_HIGH_EF];
        end
    end

    // Hardware events for the sticky event register.
    always_comb
    begin
        evtSet = 4'h0;
        bankRejected = extBank && (wrBank || panelBankReq);
        evtSet[cifr_pkg::EVT_IND] = inRise && (st_ff.cfg[cifr_pkg::CFG_IND_RST]
            || st_ff.cfg[cifr_pkg::CFG_REL_RST] || st_ff.cfg[cifr_pkg::CFG_FULL_RST]);
        evtSet[cifr_pkg::EVT_REL] = inRise && (st_ff.cfg[cifr_pkg::CFG_REL_RST]
            || st_ff.cfg[cifr_pkg::CFG_FULL_RST]);
        evtSet[cifr_pkg::EVT_FULL] = inRise && st_ff.cfg[cifr_pkg::CFG_FULL_RST];
        evtSet[cifr_pkg::EVT_REJ] = bankRejected;
    end

    // Next state of the whole router.
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.prevIn = externalControlInput;
        if (wrCfg)
        begin
            nxt_st.cfg = wrData[7:0];
        end
        if (!extBank)
        begin
            if (wrBank)
            begin
                nxt_st.bankReq = wrData[0];
            end
            else if (panelBankReq)
            begin
                nxt_st.bankReq = panelBankSel;
            end
        end
        if (extBank)
        begin
            nxt_st.bank = externalControlInput ? cifr_pkg::BANK_SECOND : cifr_pkg::BANK_MAIN;
        end
        else
        begin
            nxt_st.bank = st_ff.bankReq;
        end
        nxt_st.blk = blkNow;
        nxt_st.indPulse = evtSet[cifr_pkg::EVT_IND];
        nxt_st.relPulse = evtSet[cifr_pkg::EVT_REL];
        nxt_st.fullPulse = evtSet[cifr_pkg::EVT_FULL];
        if (wrEvt)
        begin
            nxt_st.evt = st_ff.evt & ~wrData[3:0];
        end
        nxt_st.evt = nxt_st.evt | evtSet;
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff.cfg <= cifr_pkg::CFG_RST;
            st_ff.bankReq <= cifr_pkg::BANK_MAIN;
            st_ff.prevIn <= 1'b0;
            st_ff.blk <= 4'h0;
            st_ff.bank <= cifr_pkg::BANK_MAIN;
            st_ff.indPulse <= 1'b0;
            st_ff.relPulse <= 1'b0;
            st_ff.fullPulse <= 1'b0;
            st_ff.evt <= cifr_pkg::EVT_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Read data mux; unmapped addresses read zero.
    always_comb
    begin
        rdData = cifr_pkg::DATA_ZERO;
        case (rdAddr)
            cifr_pkg::CFG_OFS:
            begin
                rdData[7:0] = st_ff.cfg;
            end
            cifr_pkg::BANK_OFS:
            begin
                rdData[0] = st_ff.bankReq;
            end
            cifr_pkg::STAT_OFS:
            begin
                rdData[cifr_pkg::STAT_IN] = st_ff.prevIn;
                rdData[cifr_pkg::STAT_BLK_LSB +: 4] = st_ff.blk;
                rdData[cifr_pkg::STAT_BANK] = st_ff.bank;
                rdData[cifr_pkg::STAT_EXT] = extBank;
            end
            cifr_pkg::EVT_OFS:
            begin
                rdData[3:0] = st_ff.evt;
            end
            default:
            begin
                rdData = cifr_pkg::DATA_ZERO;
            end
        endcase
    end

    assign blockLowOc = st_ff.blk[0];
    assign blockHighOc = st_ff.blk[1];
    assign blockLowEarthFault = st_ff.blk[2];
    assign blockHighEarthFault = st_ff.blk[3];
    assign activeBank = st_ff.bank;
    assign indicatorResetPulse = st_ff.indPulse;
    assign relayResetPulse = st_ff.relPulse;
    assign fullResetPulse = st_ff.fullPulse;

endmodule : cifr_router

`default_nettype wire

//--- cifr_router_monitor.sv
// Port assertions for the control input router.
// Assumes it is bound onto cifr_router.
`timescale 1ns/1ps
`default_nettype none
module cifr_router_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic externalControlInput,
    input wire logic blockLowOc,
    input wire logic blockHighOc,
    input wire logic blockLowEarthFault,
    input wire logic blockHighEarthFault,
    input wire logic indicatorResetPulse,
    input wire logic relayResetPulse,
    input wire logic fullResetPulse,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    logic [1:0] upCnt_ff;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // Counts edges since reset so that past values from reset are skipped.
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            upCnt_ff <= 2'h0;
        else if (upCnt_ff != 2'h3)
            upCnt_ff <= upCnt_ff + 2'h1;
    end
    sequence s_in_high;
        $past(externalControlInput);
    endsequence
    sequence s_in_rose;
        $past(externalControlInput) && !$past(externalControlInput, 2);
    endsequence
    a_blk_oc: assert property ((blockLowOc || blockHighOc) |-> s_in_high)
        else $error("overcurrent block without input");
    a_blk_ef: assert property ((blockLowEarthFault || blockHighEarthFault) |-> s_in_high)
        else $error("earth fault block without input");
    a_ind_edge: assert property (indicatorResetPulse && upCnt_ff >= 2'h2 |-> s_in_rose)
        else $error("reset pulse without rising input");
    a_pulse_once: assert property (indicatorResetPulse |=> !indicatorResetPulse)
        else $error("reset pulse longer than one cycle");
    a_rel_ind: assert property (relayResetPulse |-> indicatorResetPulse)
        else $error("relay reset without indicator reset");
    a_full_rel: assert property (fullResetPulse |-> relayResetPulse && indicatorResetPulse)
        else $error("full reset incomplete");
    a_rd_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rv_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped");
    a_bv_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
endmodule : cifr_router_monitor
bind cifr_router cifr_router_monitor cifr_router_monitor_i (.core_clk(core_clk), .sys_rst(sys_rst),
    .externalControlInput(externalControlInput), .blockLowOc(blockLowOc), .blockHighOc(blockHighOc),
    .blockLowEarthFault(blockLowEarthFault), .blockHighEarthFault(blockHighEarthFault),
    .indicatorResetPulse(indicatorResetPulse), .relayResetPulse(relayResetPulse),
    .fullResetPulse(fullResetPulse), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready));
`default_nettype wire

//--- cifr_wiring_model.sv
// Model of the substation wiring that drives the control input.
// Assumes the bench commands the level; slow adds wiring delay.
`timescale 1ns/1ps
`default_nettype none
module cifr_wiring_model (
    input wire logic core_clk,
    input wire logic cmdLevel,
    input wire logic slow,
    output logic externalControlInput
);
    logic [3:0] dly_ff = 4'h0;
    // The wire holds a steady level; only the delay to a new level varies.
    always @(posedge core_clk)
    begin
        dly_ff <= {dly_ff[2:0], cmdLevel};
    end
    assign externalControlInput = slow ? dly_ff[3] : dly_ff[0];
endmodule : cifr_wiring_model
`default_nettype wire

//--- cifr_router_tb.sv
// Self-checking bench for the control input router.
// Assumes the monitor binds itself and the wiring model drives the input.
`timescale 1ns/1ps
`default_nettype none
module cifr_router_tb;
    logic core_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cmdLevel, slow;
    logic externalControlInput, panelBankReq, panelBankSel, blockLowOc, blockHighOc, activeBank;
    logic blockLowEarthFault, blockHighEarthFault, indicatorResetPulse, relayResetPulse, fullResetPulse;
    logic [7:0] s_axi_awaddr, s_axi_araddr, cfg;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [15:0] seed;
    int nErrors = 0, testsRun = 0, nInd = 0, nRel = 0, nFull = 0, i0, i1, i2;
    cifr_router cifr_router_i (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .externalControlInput(externalControlInput),
        .panelBankReq(panelBankReq), .panelBankSel(panelBankSel), .blockLowOc(blockLowOc),
        .blockHighOc(blockHighOc), .blockLowEarthFault(blockLowEarthFault),
        .blockHighEarthFault(blockHighEarthFault), .activeBank(activeBank),
        .indicatorResetPulse(indicatorResetPulse), .relayResetPulse(relayResetPulse),
        .fullResetPulse(fullResetPulse));
    cifr_wiring_model cifr_wiring_model_i (.core_clk(core_clk), .cmdLevel(cmdLevel), .slow(slow),
        .externalControlInput(externalControlInput));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [31:0] expBlk(input logic [7:0] c, input logic v);
        expBlk = v ? {28'h000_0000, c[3:0]} : 32'h0000_0000;
    endfunction : expBlk
    function automatic logic [31:0] expP(input logic [7:0] c, input int k);
        expP = {31'h0000_0000, k == 0 ? |c[7:5] : k == 1 ? |c[7:6] : c[7]};
    endfunction : expP
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            nErrors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw = 1'b1;
        logic w = 1'b1;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge core_clk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        while (aw || w);
        while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask : rdr
    task automatic settle;
        repeat (8) @(posedge core_clk);
    endtask : settle
    task automatic lvl(input logic v);
        cmdLevel <= v;
        settle();
    endtask : lvl
    task automatic pnl(input logic s);
        @(posedge core_clk);
        {panelBankReq, panelBankSel} <= {1'b1, s};
        @(posedge core_clk);
        panelBankReq <= 1'b0;
        settle();
    endtask : pnl
    task automatic wrap_up;
        if (nErrors == 0 && testsRun > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    always @(posedge core_clk)
    begin
        nInd += indicatorResetPulse;
        nRel += relayResetPulse;
        nFull += fullResetPulse;
    end
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk);
        nErrors++;
        wrap_up();
    end
    initial
    begin
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready, cmdLevel, slow, panelBankReq, panelBankSel} = '0;
        seed = 16'h95E4;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        rdr(cifr_pkg::CFG_OFS);
        chk(rd, 32'h0000_0000);
        rdr(8'h10);
        chk(rsp, cifr_pkg::RESP_SLVERR);
        wr(8'h14, 32'h0000_00FF);
        chk(rsp, cifr_pkg::RESP_SLVERR);
        for (int k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            cfg = (k == 0) ? 8'h00 : {4'h0, seed[3:0]};
            wr(cifr_pkg::CFG_OFS, {24'h00_0000, cfg});
            rdr(cifr_pkg::CFG_OFS);
            chk(rd, {24'h00_0000, cfg});
            slow <= seed[5];
            lvl(1'b1);
            chk({blockHighEarthFault, blockLowEarthFault, blockHighOc, blockLowOc}, expBlk(cfg, 1'b1));
            lvl(1'b0);
            chk({blockHighEarthFault, blockLowEarthFault, blockHighOc, blockLowOc}, expBlk(cfg, 1'b0));
        end
        wr(cifr_pkg::CFG_OFS, 32'h0000_0000);
        wr(cifr_pkg::BANK_OFS, 32'h0000_0001);
        settle();
        chk(activeBank, cifr_pkg::BANK_SECOND);
        pnl(1'b0);
        chk(activeBank, cifr_pkg::BANK_MAIN);
        wr(cifr_pkg::CFG_OFS, 32'h0000_0010);
        pnl(1'b1);
        chk(activeBank, cifr_pkg::BANK_MAIN);
        lvl(1'b1);
        chk(activeBank, cifr_pkg::BANK_SECOND);
        wr(cifr_pkg::BANK_OFS, 32'h0000_0001);
        pnl(1'b1);
        chk(activeBank, cifr_pkg::BANK_SECOND);
        rdr(cifr_pkg::EVT_OFS);
        chk(rd[cifr_pkg::EVT_REJ], 1'b1);
        lvl(1'b0);
        chk(activeBank, cifr_pkg::BANK_MAIN);
        wr(cifr_pkg::CFG_OFS, 32'h0000_0000);
        settle();
        chk(activeBank, cifr_pkg::BANK_MAIN);
        for (int k = 0; k < 4; k++)
        begin
            cfg = (k == 0) ? 8'h00 : 8'h10 << k;
            wr(cifr_pkg::CFG_OFS, {24'h00_0000, cfg});
            {i0, i1, i2} = {nInd, nRel, nFull};
            slow <= k[0];
            lvl(1'b1);
            lvl(1'b0);
            chk(nInd - i0, expP(cfg, 0));
            chk(nRel - i1, expP(cfg, 1));
            chk(nFull - i2, expP(cfg, 2));
        end
        sys_rst <= 1'b1;
        settle();
        sys_rst <= 1'b0;
        rdr(cifr_pkg::CFG_OFS);
        chk(rd, 32'h0000_0000);
        wrap_up();
    end
endmodule : cifr_router_tb
`default_nettype wire
